// ### pkg/page_b_pkg.sv
`default_nettype none
package page_b_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam int REG_W = 8;
  localparam int ROW_W = 5;
  localparam int ROM_W = 12;
  localparam int LANG_W = 3;
  localparam int BLOCKS_DEFAULT = 10;

  localparam logic [ADDR_W-1:0] OFF_ROW_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_GP_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ROM_A_UPPER = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ROM_B_LOW = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ROM_B_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PKT_LOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PKT_HIGH = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;

  localparam int CTRL_TWIST_LSB = 0;
  localparam int CTRL_TWIST_MSB = 2;
  localparam int CTRL_HALF = 3;
  localparam int CTRL_DOUBLE = 4;
  localparam int CTRL_STATUS_TOP = 5;
  localparam int CTRL_SOURCE = 6;
  localparam int CTRL_STATUS_ONLY = 7;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

  localparam logic [1:0] CORE_CLOCK_12MHZ = 2'h1;
  localparam int GPF_CLK_LSB = 0;
  localparam int GPF_CLK_MSB = 1;
  localparam int GPF_UPPER_LSB = 2;
  localparam int GPF_UPPER_MSB = 3;
  localparam int ROM_FLAGS_LSB = 10;
  localparam int ROM_FLAGS_MSB = 11;
  localparam int ROM_A_CFG_LSB = 5;
  localparam int ROM_A_CFG_MSB = 11;
  localparam int ROM_A_RSVD_POS = 7;
  localparam int ROM_B_LOW_MSB = 7;
  localparam int ROM_B_HIGH_LSB = 8;
  localparam int ROM_B_HIGH_MSB = 11;

  localparam logic [ROW_W-1:0] ROW_FIRST = 5'h00;
  localparam logic [ROW_W-1:0] ROW_ONE = 5'h01;
  localparam logic [ROW_W-1:0] ROW_HALF_BASE = 5'h0C;
  localparam logic [ROW_W-1:0] ROW_STATUS = 5'h18;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01,
    BUS_HOLD = 2'b11
  } bus_state_e;
endpackage : page_b_pkg
`default_nettype wire

// ### hdl/packet_flag_bank.sv
`default_nettype none
module packet_flag_bank
  import page_b_pkg::*;
#(
  parameter int NUM_BLOCKS = BLOCKS_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [NUM_BLOCKS-1:0] set_i,
  input wire logic [NUM_BLOCKS-1:0] clear_i,
  output logic [NUM_BLOCKS-1:0] flags_o,
  output logic [NUM_BLOCKS-1:0] event_o
);
  if (NUM_BLOCKS < 1) begin : bad_blocks
    $error("packet_flag_bank needs at least one block");
  end

  genvar b;
  for (b = 0; b < NUM_BLOCKS; b = b + 1) begin : g_flag
    logic flag_reg;
    logic flag_next;

    // Set beats clear so a reception in the clearing cycle survives
    always_comb
    begin
      flag_next = flag_reg;
      if (clear_i[b])
      begin
        flag_next = 1'b0;
      end
      if (set_i[b])
      begin
        flag_next = 1'b1;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        flag_reg <= 1'b0;
      end
      else if (ce_i)
      begin
        flag_reg <= flag_next;
      end
    end

    assign flags_o[b] = flag_reg;
    assign event_o[b] = set_i[b] & ce_i;
  end
endmodule : packet_flag_bank
`default_nettype wire

// ### hdl/page_b_row_control.sv
// Function
// - Three-bit language code selects twist character set
// - Half select picks rows 0-11 or 12-23
// - Double-height bit doubles character height on every row except the status row
// - Status row below page or above page
// - Row 24 from basic or extension memory
// - Status-row-only shows row 24 alone
// - Clock config field reads 01 for 12 MHz
// - Upper flag bits come from ROM word 09FEH
// - ROM word 09FFH bits 11..5 readable, one reserved
// - Low flag register holds blocks 7 to 0
// - High flag register holds blocks 9 and 8
// - Hardware sets block flag, only software clears
//
// Our own choices: register access over Wishbone and the register offsets.
`default_nettype none
module page_b_row_control
  import page_b_pkg::*;
#(
  parameter int NUM_BLOCKS = BLOCKS_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [ROM_W-1:0] rom_flag_word_i,
  input wire logic [ROM_W-1:0] rom_word_a_i,
  input wire logic [ROM_W-1:0] rom_word_b_i,
  input wire logic [NUM_BLOCKS-1:0] acq_block_done_i,
  input wire logic [ROW_W-1:0] disp_row_i,
  input wire logic [LANG_W-1:0] language_code_i,
  output logic [LANG_W-1:0] twist_language_select_o,
  output logic twist_active_o,
  output logic double_height_o,
  output logic double_height_half_select_o,
  output logic status_row_top_o,
  output logic status_row_source_select_o,
  output logic status_row_only_o,
  output logic [ROW_W-1:0] mem_row_o,
  output logic row_visible_o,
  output logic row_from_ext_o,
  output logic [NUM_BLOCKS-1:0] block_packet_seen_o
);
  localparam int HIGH_W = NUM_BLOCKS - REG_W;

  // Two byte-wide flag registers can only cover sixteen blocks
  if (NUM_BLOCKS <= REG_W || NUM_BLOCKS > 2 * REG_W) begin : bad_blocks
    $error("NUM_BLOCKS must lie between 9 and 16");
  end

  bus_state_e bus_state_reg;
  bus_state_e bus_state_next;
  logic [REG_W-1:0] ctrl_reg;
  logic [NUM_BLOCKS-1:0] irq_status_reg;
  logic [NUM_BLOCKS-1:0] irq_status_next;
  logic [NUM_BLOCKS-1:0] irq_mask_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic irq_reg;
  logic req;
  logic wr_fire;
  logic rd_fire;
  logic lane0;
  logic [NUM_BLOCKS-1:0] sw_clear;
  logic [NUM_BLOCKS-1:0] flags;
  logic [NUM_BLOCKS-1:0] flag_events;
  logic [REG_W-1:0] gp_flags;
  logic [REG_W-1:0] rom_a_upper;
  logic [REG_W-1:0] rom_b_low;
  logic [REG_W-1:0] rom_b_high;
  logic [REG_W-1:0] pkt_low;
  logic [REG_W-1:0] pkt_high;

  logic [LANG_W-1:0] twist_sel_reg;
  logic twist_active_reg;
  logic double_reg;
  logic half_reg;
  logic status_top_reg;
  logic source_reg;
  logic status_only_reg;
  logic [ROW_W-1:0] mem_row_reg;
  logic [ROW_W-1:0] mem_row_next;
  logic visible_reg;
  logic visible_next;
  logic from_ext_reg;
  logic from_ext_next;
  logic status_slot;
  logic [ROW_W-1:0] page_row;
  logic [ROW_W-1:0] half_base;

  // Bus handshake
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_fire = ce_i & req & wb_we_i & (bus_state_reg == BUS_ACK);
  assign rd_fire = ce_i & req & ~wb_we_i & (bus_state_reg == BUS_ACK);
  assign lane0 = wb_sel_i[0];

  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE:
      begin
        if (req)
        begin
          bus_state_next = BUS_ACK;
        end
      end
      BUS_ACK:
      begin
        bus_state_next = BUS_HOLD;
      end
      BUS_HOLD:
      begin
        // Waiting for release stops a held strobe from retriggering
        if (!req)
        begin
          bus_state_next = BUS_IDLE;
        end
      end
      default:
      begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state_reg <= BUS_IDLE;
    end
    else if (ce_i)
    begin
      bus_state_reg <= bus_state_next;
    end
  end

  assign wb_ack_o = (bus_state_reg == BUS_ACK);
  assign wb_dat_o = rd_data_reg;

  // Read-only views
  always_comb
  begin
    gp_flags = '0;
    gp_flags[GPF_CLK_MSB:GPF_CLK_LSB] = CORE_CLOCK_12MHZ;
    gp_flags[GPF_UPPER_MSB:GPF_UPPER_LSB] =
      rom_flag_word_i[ROM_FLAGS_MSB:ROM_FLAGS_LSB];
  end

  always_comb
  begin
    rom_a_upper = '0;
    rom_a_upper[ROM_A_RSVD_POS] = 1'b0;
    rom_a_upper[ROM_A_CFG_MSB-ROM_A_CFG_LSB:0] =
      rom_word_a_i[ROM_A_CFG_MSB:ROM_A_CFG_LSB];
  end

  always_comb
  begin
    rom_b_low = rom_word_b_i[ROM_B_LOW_MSB:0];
    rom_b_high = '0;
    rom_b_high[ROM_B_HIGH_MSB-ROM_B_HIGH_LSB:0] =
      rom_word_b_i[ROM_B_HIGH_MSB:ROM_B_HIGH_LSB];
  end

  always_comb
  begin
    pkt_low = flags[REG_W-1:0];
    pkt_high = '0;
    pkt_high[HIGH_W-1:0] = flags[NUM_BLOCKS-1:REG_W];
  end

  // Read data captured as the request is seen, presented with ack
  always_comb
  begin
    rd_data_next = '0;
    case (wb_adr_i)
      OFF_ROW_CTRL: rd_data_next[REG_W-1:0] = ctrl_reg;
      OFF_GP_FLAGS: rd_data_next[REG_W-1:0] = gp_flags;
      OFF_ROM_A_UPPER: rd_data_next[REG_W-1:0] = rom_a_upper;
      OFF_ROM_B_LOW: rd_data_next[REG_W-1:0] = rom_b_low;
      OFF_ROM_B_HIGH: rd_data_next[REG_W-1:0] = rom_b_high;
      OFF_PKT_LOW: rd_data_next[REG_W-1:0] = pkt_low;
      OFF_PKT_HIGH: rd_data_next[REG_W-1:0] = pkt_high;
      OFF_IRQ_STATUS: rd_data_next[NUM_BLOCKS-1:0] = irq_status_reg;
      OFF_IRQ_MASK: rd_data_next[NUM_BLOCKS-1:0] = irq_mask_reg;
      default: rd_data_next = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_reg <= '0;
    end
    else if (ce_i && bus_state_reg == BUS_IDLE && req)
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (wr_fire && lane0 && wb_adr_i == OFF_ROW_CTRL)
    begin
      ctrl_reg <= wb_dat_i[REG_W-1:0];
    end
  end

  // Write one to clear packet flags; software cannot set them
  always_comb
  begin
    sw_clear = '0;
    if (wr_fire && lane0 && wb_adr_i == OFF_PKT_LOW)
    begin
      sw_clear[REG_W-1:0] = wb_dat_i[REG_W-1:0];
    end
    if (wr_fire && lane0 && wb_adr_i == OFF_PKT_HIGH)
    begin
      sw_clear[NUM_BLOCKS-1:REG_W] = wb_dat_i[HIGH_W-1:0];
    end
  end

  packet_flag_bank #(
    .NUM_BLOCKS(NUM_BLOCKS)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(acq_block_done_i),
    .clear_i(sw_clear),
    .flags_o(flags),
    .event_o(flag_events)
  );

  assign block_packet_seen_o = flags;

  // Interrupts: read clears only the bits that were returned
  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (rd_fire && wb_adr_i == OFF_IRQ_STATUS)
    begin
      irq_status_next = irq_status_reg & ~rd_data_reg[NUM_BLOCKS-1:0];
    end
    irq_status_next = irq_status_next | flag_events;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_reg <= '0;
    end
    else if (ce_i)
    begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_mask_reg <= '0;
    end
    else if (wr_fire && wb_adr_i == OFF_IRQ_MASK)
    begin
      irq_mask_reg <= wb_dat_i[NUM_BLOCKS-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  assign irq_o = irq_reg;

  // Row mapping for the display engine
  assign status_slot = ctrl_reg[CTRL_STATUS_TOP] ? (disp_row_i == ROW_FIRST)
                                                 : (disp_row_i == ROW_STATUS);
  assign page_row = ctrl_reg[CTRL_STATUS_TOP] ? disp_row_i - ROW_ONE : disp_row_i;
  assign half_base = ctrl_reg[CTRL_HALF] ? ROW_HALF_BASE : ROW_FIRST;

  always_comb
  begin
    mem_row_next = page_row;
    visible_next = (disp_row_i <= ROW_STATUS);
    from_ext_next = 1'b0;
    if (ctrl_reg[CTRL_DOUBLE])
    begin
      // Each memory row spans two display rows
      mem_row_next = half_base + (page_row >> 1);
    end
    if (status_slot)
    begin
      mem_row_next = ROW_STATUS;
      from_ext_next = ctrl_reg[CTRL_SOURCE];
    end
    else if (ctrl_reg[CTRL_STATUS_ONLY])
    begin
      visible_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_row_reg <= ROW_FIRST;
      visible_reg <= 1'b0;
      from_ext_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      mem_row_reg <= mem_row_next;
      visible_reg <= visible_next;
      from_ext_reg <= from_ext_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      twist_sel_reg <= '0;
      twist_active_reg <= 1'b0;
      double_reg <= 1'b0;
      half_reg <= 1'b0;
      status_top_reg <= 1'b0;
      source_reg <= 1'b0;
      status_only_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      twist_sel_reg <= ctrl_reg[CTRL_TWIST_MSB:CTRL_TWIST_LSB];
      twist_active_reg <= (language_code_i == ctrl_reg[CTRL_TWIST_MSB:CTRL_TWIST_LSB]);
      double_reg <= ctrl_reg[CTRL_DOUBLE];
      half_reg <= ctrl_reg[CTRL_HALF];
      status_top_reg <= ctrl_reg[CTRL_STATUS_TOP];
      source_reg <= ctrl_reg[CTRL_SOURCE];
      status_only_reg <= ctrl_reg[CTRL_STATUS_ONLY];
    end
  end

  assign twist_language_select_o = twist_sel_reg;
  assign twist_active_o = twist_active_reg;
  assign double_height_o = double_reg;
  assign double_height_half_select_o = half_reg;
  assign status_row_top_o = status_top_reg;
  assign status_row_source_select_o = source_reg;
  assign status_row_only_o = status_only_reg;
  assign mem_row_o = mem_row_reg;
  assign row_visible_o = visible_reg;
  assign row_from_ext_o = from_ext_reg;
endmodule : page_b_row_control
`default_nettype wire

// ### verif/row_control_properties.sv
`default_nettype none
module row_control_checker
  import page_b_pkg::*;
#(
  parameter int NUM_BLOCKS = BLOCKS_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic [NUM_BLOCKS-1:0] acq_block_done_i,
  input wire logic [ROW_W-1:0] disp_row_i,
  input wire logic [LANG_W-1:0] language_code_i,
  input wire logic [LANG_W-1:0] twist_language_select_o,
  input wire logic twist_active_o,
  input wire logic double_height_o,
  input wire logic double_height_half_select_o,
  input wire logic status_row_top_o,
  input wire logic status_row_source_select_o,
  input wire logic status_row_only_o,
  input wire logic [ROW_W-1:0] mem_row_o,
  input wire logic row_visible_o,
  input wire logic row_from_ext_o,
  input wire logic [NUM_BLOCKS-1:0] block_packet_seen_o
);
  logic live_reg;
  logic [ROW_W-1:0] row_reg;
  logic [LANG_W-1:0] lang_reg;
  // Last-cycle inputs; live_reg skips the edge right after reset
  always_ff @(posedge clk_i)
  begin
    live_reg <= !rst_i && ce_i;
    row_reg <= disp_row_i;
    lang_reg <= language_code_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_flag_set_next: assert property ((ce_i && |acq_block_done_i) |=>
    (block_packet_seen_o & $past(acq_block_done_i)) == $past(acq_block_done_i))
    else $error("flag not set after event");
  a_flag_sw_clear: assert property (
    (~block_packet_seen_o & $past(block_packet_seen_o)) != '0 |-> $past(wb_ack_o && wb_we_i))
    else $error("flag cleared without write");
  a_twist_compare: assert property (
    live_reg |-> twist_active_o == (lang_reg == twist_language_select_o))
    else $error("twist match wrong");
  a_status_row_slot: assert property (
    (live_reg && row_reg == (status_row_top_o ? ROW_FIRST : ROW_STATUS)) |-> row_visible_o
    && mem_row_o == ROW_STATUS && row_from_ext_o == status_row_source_select_o)
    else $error("status row slot wrong");
  a_status_only_hides: assert property (
    (live_reg && status_row_only_o && row_visible_o) |-> mem_row_o == ROW_STATUS)
    else $error("row shown in status-only mode");
  a_double_height_rows: assert property ((live_reg && double_height_o
    && !status_row_top_o && !status_row_only_o && row_reg < ROW_STATUS) |-> row_visible_o
    && mem_row_o == (double_height_half_select_o ? ROW_HALF_BASE : ROW_FIRST) + (row_reg >> 1))
    else $error("double height row wrong");
  c_write_done: cover property (wb_ack_o && wb_we_i);
  c_irq_rise: cover property ($rose(irq_o));
  c_status_on_top: cover property (live_reg && status_row_top_o && row_reg == ROW_FIRST);
endmodule : row_control_checker
bind page_b_row_control row_control_checker #(.NUM_BLOCKS(NUM_BLOCKS)) u_checker (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .irq_o,
  .acq_block_done_i, .disp_row_i, .language_code_i, .twist_language_select_o,
  .twist_active_o, .double_height_o, .double_height_half_select_o, .status_row_top_o,
  .status_row_source_select_o, .status_row_only_o, .mem_row_o, .row_visible_o,
  .row_from_ext_o, .block_packet_seen_o);
`default_nettype wire

// ### verif/tb_top.sv
`default_nettype none
module tb_top
  import page_b_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [SEL_W-1:0] wb_sel_i;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o, rd;
  logic [9:0] acq_block_done_i, block_packet_seen_o;
  logic [ROW_W-1:0] disp_row_i, mem_row_o;
  logic [LANG_W-1:0] language_code_i, twist_language_select_o;
  logic twist_active_o, double_height_o, double_height_half_select_o, status_row_top_o;
  logic status_row_source_select_o, status_row_only_o, row_visible_o, row_from_ext_o;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  // ROM words fixed: they are static in the real part
  page_b_row_control #(.NUM_BLOCKS(10)) dut (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .rom_flag_word_i(12'h8F3),
    .rom_word_a_i(12'hFE0), .rom_word_b_i(12'h5A3), .acq_block_done_i, .disp_row_i,
    .language_code_i, .twist_language_select_o, .twist_active_o, .double_height_o,
    .double_height_half_select_o, .status_row_top_o, .status_row_source_select_o,
    .status_row_only_o, .mem_row_o, .row_visible_o, .row_from_ext_o, .block_packet_seen_o);
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Optional event p lands in the ack cycle, colliding with a flag clear
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    input logic [SEL_W-1:0] s, input logic [9:0] p);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clk_i);
      acq_block_done_i <= (n == 0) ? p : 10'h000;
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF, 10'h000);
    chk("read data", exp, rd);
  endtask : rchk
  task automatic rowchk(input logic [ROW_W-1:0] r, input logic [6:0] exp);
    disp_row_i <= r;
    repeat (2) @(posedge clk_i);
    chk("row map", {25'h0, exp},
      {25'h0, row_visible_o ? {mem_row_o, 1'b1, row_from_ext_o} : 7'h00});
  endtask : rowchk
  // Waits an edge first: the bus task may have just driven the event lines
  task automatic pulse(input logic [9:0] p);
    @(posedge clk_i);
    acq_block_done_i <= p;
    @(posedge clk_i);
    acq_block_done_i <= 10'h000;
    @(posedge clk_i);
  endtask : pulse
  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    acq_block_done_i = 10'h000;
    disp_row_i = 5'h00;
    language_code_i = 3'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(OFF_ROW_CTRL, 32'h00);
    rchk(OFF_GP_FLAGS, 32'h09);
    rchk(OFF_ROM_A_UPPER, 32'h7F);
    rchk(OFF_ROM_B_LOW, 32'hA3);
    rchk(OFF_ROM_B_HIGH, 32'h05);
    bus(1'b1, OFF_GP_FLAGS, 32'hFF, 4'hF, 10'h000);
    rchk(OFF_GP_FLAGS, 32'h09);
    bus(1'b1, 8'h40, 32'hFF, 4'hF, 10'h000);
    rchk(8'h40, 32'h00);
    bus(1'b1, OFF_ROW_CTRL, 32'hFF, 4'hE, 10'h000);
    rchk(OFF_ROW_CTRL, 32'h00);
    bus(1'b1, OFF_ROW_CTRL, 32'h1D, 4'hF, 10'h000);
    rchk(OFF_ROW_CTRL, 32'h1D);
    language_code_i <= 3'h5;
    rowchk(5'h04, 7'h3A);
    chk("control outputs", 32'h11D, {23'h0, twist_active_o, status_row_only_o,
      status_row_source_select_o, status_row_top_o, double_height_o,
      double_height_half_select_o, twist_language_select_o});
    rowchk(5'h17, 7'h5E);
    rowchk(5'h18, 7'h62);
    bus(1'b1, OFF_ROW_CTRL, 32'h15, 4'hF, 10'h000);
    rowchk(5'h17, 7'h2E);
    bus(1'b1, OFF_ROW_CTRL, 32'h60, 4'hF, 10'h000);
    rowchk(5'h00, 7'h63);
    rowchk(5'h05, 7'h12);
    bus(1'b1, OFF_ROW_CTRL, 32'hC0, 4'hF, 10'h000);
    rowchk(5'h03, 7'h00);
    rowchk(5'h18, 7'h63);
    bus(1'b1, OFF_IRQ_MASK, 32'h200, 4'hF, 10'h000);
    pulse(10'h001);
    chk("irq", 32'h0, {31'h0, irq_o});
    pulse(10'h200);
    chk("irq", 32'h1, {31'h0, irq_o});
    chk("seen flags", 32'h201, {22'h0, block_packet_seen_o});
    rchk(OFF_PKT_LOW, 32'h01);
    rchk(OFF_PKT_HIGH, 32'h02);
    rchk(OFF_IRQ_STATUS, 32'h201);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    rchk(OFF_IRQ_STATUS, 32'h0);
    rchk(OFF_PKT_LOW, 32'h01);
    bus(1'b1, OFF_PKT_LOW, 32'h01, 4'hF, 10'h001);
    rchk(OFF_PKT_LOW, 32'h01);
    bus(1'b1, OFF_PKT_LOW, 32'hFF, 4'hF, 10'h000);
    bus(1'b1, OFF_PKT_HIGH, 32'h02, 4'hF, 10'h000);
    rchk(OFF_PKT_LOW, 32'h00);
    rchk(OFF_PKT_HIGH, 32'h00);
    // Frozen block must ignore an event
    ce_i <= 1'b0;
    pulse(10'h004);
    ce_i <= 1'b1;
    chk("frozen flags", 32'h0, {22'h0, block_packet_seen_o});
    pulse(10'h004);
    rchk(OFF_PKT_LOW, 32'h04);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
